// file: tb/tb_top.sv
/*
 * Self-checking bench for file_alu_bit_ops_exec: directed corner cases, then seeded random instructions.
 * Assumes exec_pkg is compiled first and that the file space answers reads combinationally.
 */
`timescale 1ns/1ps
module tb_top;
    logic MCLK_I = 1'b0;
    logic RESET_I = 1'b1;
    logic INSN_VALID_I = 1'b0;
    logic [13:0] INSN_I = 14'h0000;
    logic [7:0] FILE_RDATA_I = 8'h00;
    logic [7:0] PIN_RDATA_I = 8'h00;
    logic IS_PORT_I = 1'b0;
    logic [6:0] FILE_ADDR_O;
    logic [6:0] FILE_WADDR_O;
    logic [7:0] ACC_O;
    logic [7:0] FILE_WDATA_O;
    logic CARRY_O;
    logic HALF_OVERFLOW_BIT_O;
    logic NULL_O;
    logic FILE_WE_O;
    logic DISCARD_O;
    logic DONE_O;
    int n_mismatch = 0;
    int n_tests = 0;
    int seed = 32'h977ACE35;
    // Reference model state; expectations lag the stimulus by one edge.
    logic [7:0] m_acc = 8'h00;
    logic [7:0] e_wd = 8'h00;
    logic [6:0] e_wa = 7'h00;
    logic m_c = 1'b0, m_h = 1'b0, m_z = 1'b0, m_skip = 1'b0;
    logic e_we = 1'b0, e_dis = 1'b0, e_done = 1'b0;
    logic [13:0] base [4] = '{14'h0700, 14'h0500, 14'h1000, 14'h1800};
    logic [13:0] w;
    int k;

    file_alu_bit_ops_exec file_alu_bit_ops_exec_i (.MCLK_I(MCLK_I), .RESET_I(RESET_I),
        .INSN_VALID_I(INSN_VALID_I), .INSN_I(INSN_I), .FILE_RDATA_I(FILE_RDATA_I),
        .PIN_RDATA_I(PIN_RDATA_I), .IS_PORT_I(IS_PORT_I), .FILE_ADDR_O(FILE_ADDR_O), .ACC_O(ACC_O),
        .CARRY_O(CARRY_O), .HALF_OVERFLOW_BIT_O(HALF_OVERFLOW_BIT_O), .NULL_O(NULL_O),
        .FILE_WE_O(FILE_WE_O), .FILE_WADDR_O(FILE_WADDR_O), .FILE_WDATA_O(FILE_WDATA_O),
        .DISCARD_O(DISCARD_O), .DONE_O(DONE_O));

    // The clock toggles every half period of 12.5 ns.
    always #12.5 MCLK_I = ~MCLK_I;

    // Carry out of the low nibble, worked out apart from the byte sum.
    function automatic logic half_c(input logic [7:0] a, input logic [7:0] b);
        return ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
    endfunction : half_c

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk1

    // Presents one word, checks the previous word's effect, then predicts this one.
    task automatic step(input logic v, input logic [13:0] iw, input logic [7:0] rd, input logic [7:0] pn,
                        input logic pt);
        logic [7:0] op;
        logic [8:0] s;
        logic [7:0] r;
        logic byte_op;
        @(posedge MCLK_I);
        INSN_VALID_I <= v;
        INSN_I <= iw;
        FILE_RDATA_I <= rd;
        PIN_RDATA_I <= pn;
        IS_PORT_I <= pt;
        #1;
        chk8(ACC_O, m_acc);
        chk1(CARRY_O, m_c);
        chk1(HALF_OVERFLOW_BIT_O, m_h);
        chk1(NULL_O, m_z);
        chk1(FILE_WE_O, e_we);
        chk1(DISCARD_O, e_dis);
        chk1(DONE_O, e_done);
        if (e_we) chk8({1'b0, FILE_WADDR_O}, {1'b0, e_wa});
        if (e_we) chk8(FILE_WDATA_O, e_wd);
        chk8({1'b0, FILE_ADDR_O}, {1'b0, iw[6:0]});
        op = pt ? pn : rd;
        e_we = 1'b0;
        e_dis = 1'b0;
        e_wa = iw[6:0];
        e_done = m_skip;
        byte_op = 1'b0;
        r = 8'h00;
        // A word in the slot after a taken skip has no effect at all.
        if (m_skip) m_skip = 1'b0;
        else if (v) begin
            e_done = 1'b1;
            if (iw[13:8] == exec_pkg::OP_SUM) begin
                s = {1'b0, m_acc} + {1'b0, op};
                r = s[7:0];
                m_c = s[8];
                m_h = half_c(m_acc, op);
                byte_op = 1'b1;
            end else if (iw[13:8] == exec_pkg::OP_MASK) begin
                r = m_acc & op;
                byte_op = 1'b1;
            end else if (iw[13:10] == exec_pkg::OP_BCLR) begin
                e_we = 1'b1;
                e_wd = op & ~(8'h01 << iw[9:7]);
            end else if (iw[13:10] == exec_pkg::OP_BTST && op[iw[9:7]] == 1'b0) begin
                e_dis = 1'b1;
                e_done = 1'b0;
                m_skip = 1'b1;
            end
            if (byte_op) begin
                m_z = (r == 8'h00);
                e_we = iw[7];
                e_wd = r;
                if (!iw[7]) m_acc = r;
            end
        end
    endtask : step

    // Reset in mid-run; a pending no-operation slot must not survive it, so the model forgets it too.
    task automatic pulse_reset;
        @(posedge MCLK_I);
        RESET_I <= 1'b1;
        INSN_VALID_I <= 1'b0;
        repeat (2) @(posedge MCLK_I);
        RESET_I <= 1'b0;
        m_acc = 8'h00;
        m_c = 1'b0;
        m_h = 1'b0;
        m_z = 1'b0;
        m_skip = 1'b0;
        e_we = 1'b0;
        e_dis = 1'b0;
        e_done = 1'b0;
    endtask : pulse_reset

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    // A hang is cut short well beyond the expected run length.
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end

    // Directed corners first, then random words drawn only from the four decoded opcodes.
    initial begin
        repeat (5) @(posedge MCLK_I);
        RESET_I <= 1'b0;
        step(1'b1, 14'h0705, 8'h17, 8'h00, 1'b0);
        step(1'b1, 14'h0705, 8'hC2, 8'h00, 1'b0);
        step(1'b1, 14'h0585, 8'hC2, 8'h00, 1'b0);
        step(1'b1, 14'h0705, 8'h27, 8'h00, 1'b0);
        step(1'b1, 14'h0785, 8'h01, 8'h00, 1'b0);
        step(1'b1, 14'h1385, 8'hC7, 8'h00, 1'b0);
        step(1'b1, 14'h1005, 8'hFF, 8'h0F, 1'b1);
        step(1'b1, 14'h0505, 8'hAA, 8'h3C, 1'b1);
        step(1'b1, 14'h1805, 8'hFE, 8'h00, 1'b0);
        step(1'b1, 14'h0705, 8'h55, 8'h00, 1'b0);
        step(1'b1, 14'h1885, 8'h02, 8'h00, 1'b0);
        step(1'b1, 14'h1B85, 8'h7F, 8'h00, 1'b0);
        step(1'b1, 14'h1805, 8'h00, 8'h00, 1'b0);
        step(1'b0, 14'h0705, 8'h11, 8'h00, 1'b0);
        for (int i = 0; i < 400; i++) begin
            k = $random(seed) & 3;
            w = $random(seed);
            w = base[k] | (w & ((k < 2) ? 14'h00FF : 14'h03FF));
            step(($random(seed) & 7) != 0, w, $random(seed), $random(seed), $random(seed));
        end
        step(1'b1, 14'h1805, 8'hFE, 8'h00, 1'b0);
        pulse_reset();
        step(1'b1, 14'h0705, 8'h21, 8'h00, 1'b0);
        step(1'b0, 14'h0000, 8'h00, 8'h00, 1'b0);
        step(1'b0, 14'h0000, 8'h00, 8'h00, 1'b0);
        tally_and_finish();
    end
endmodule : tb_top

// file: verilog/alu_core.sv
/*
 * Combinational arithmetic for the execute block: add, AND, bit clear and bit test.
 * Assumes the operand is already chosen between pins and storage.
 */
`timescale 1ns/1ps
module alu_core (
    input wire logic [7:0] acc_i,
    input wire logic [7:0] opnd_i,
    input wire logic [2:0] bitsel_i,
    output logic [7:0] sum_o,
    output logic carry_o,
    output logic half_o,
    output logic [7:0] and_o,
    output logic [7:0] clr_o,
    output logic tbit_o
);
    logic [8:0] full;
    logic [4:0] low;

    // Full and low-nibble sums, from two separate adders, give carry and half carry.
    always_comb begin
        full = {1'b0, acc_i} + {1'b0, opnd_i};
        low = {1'b0, acc_i[3:0]} + {1'b0, opnd_i[3:0]};
        sum_o = full[7:0];
        carry_o = full[8];
        half_o = low[4];
        and_o = acc_i & opnd_i;
        clr_o = opnd_i & ~(8'h01 << bitsel_i);
        tbit_o = opnd_i[bitsel_i];
    end
endmodule : alu_core

// file: verilog/exec_pkg.sv
/*
 * Shared constants for the file-register execute block: opcode fields,
 * status bit positions, reset values and cycle counts.
 * Assumes a 14-bit instruction word and an 8-bit data path.
 */
package exec_pkg;
    localparam int INSN_W = 14;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    // Opcode field positions and values.
    localparam int OP_HI = 13;
    localparam int BYTE_OP_LO = 8;
    localparam int BIT_OP_LO = 10;
    localparam logic [5:0] OP_SUM = 6'h07;
    localparam logic [5:0] OP_MASK = 6'h05;
    localparam logic [3:0] OP_BCLR = 4'h4;
    localparam logic [3:0] OP_BTST = 4'h6;
    localparam int DEST_POS = 7;
    localparam int BITSEL_LO = 7;
    localparam int BITSEL_HI = 9;
    // Status bit positions in the three-bit flag group.
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_HALF = 1;
    localparam int FLAG_NULL = 2;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [2:0] FLAGS_RESET = 3'h0;
    localparam int SKIP_CYCLES = 2;
endpackage : exec_pkg

// file: verilog/file_alu_bit_ops_exec.sv
/*
 * Execute stage for four file-register instructions: sum into target,
 * mask with operand, clear a bit, and test a bit with skip on zero.
 * Assumes the fetch unit presents one instruction per cycle with a valid
 * strobe, the file space answers reads combinationally, and port registers
 * are flagged by the address decoder so their pin levels can be read.
 */
`timescale 1ns/1ps
module file_alu_bit_ops_exec (
    input wire logic MCLK_I,
    input wire logic RESET_I,
    input wire logic INSN_VALID_I,
    input wire logic [13:0] INSN_I,
    input wire logic [7:0] FILE_RDATA_I,
    input wire logic [7:0] PIN_RDATA_I,
    input wire logic IS_PORT_I,
    output logic [6:0] FILE_ADDR_O,
    output logic [7:0] ACC_O,
    output logic CARRY_O,
    output logic HALF_OVERFLOW_BIT_O,
    output logic NULL_O,
    output logic FILE_WE_O,
    output logic [6:0] FILE_WADDR_O,
    output logic [7:0] FILE_WDATA_O,
    output logic DISCARD_O,
    output logic DONE_O
);
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_NOP = 2'b10
    } state_t;

    state_t state_q;
    state_t state_d;
    logic [7:0] acc_q;
    logic [2:0] flags_q;
    logic we_q;
    logic [6:0] waddr_q;
    logic [7:0] wdata_q;
    logic discard_q;
    logic done_q;
    logic [7:0] opnd;
    logic [7:0] sum;
    logic [7:0] andv;
    logic [7:0] clrv;
    logic carry;
    logic half;
    logic tbit;
    logic live;
    logic is_sum;
    logic is_mask;
    logic is_bclr;
    logic is_btst;
    logic dest;

    // Pin levels replace the latch for port registers so inputs driven low are written back as low.
    assign opnd = IS_PORT_I ? PIN_RDATA_I : FILE_RDATA_I;
    assign FILE_ADDR_O = INSN_I[6:0];

    // Decode; the word fetched behind a taken skip is squashed here.
    assign live = INSN_VALID_I && (state_q == ST_RUN);
    assign is_sum = live && (INSN_I[exec_pkg::OP_HI:exec_pkg::BYTE_OP_LO] == exec_pkg::OP_SUM);
    assign is_mask = live && (INSN_I[exec_pkg::OP_HI:exec_pkg::BYTE_OP_LO] == exec_pkg::OP_MASK);
    assign is_bclr = live && (INSN_I[exec_pkg::OP_HI:exec_pkg::BIT_OP_LO] == exec_pkg::OP_BCLR);
    assign is_btst = live && (INSN_I[exec_pkg::OP_HI:exec_pkg::BIT_OP_LO] == exec_pkg::OP_BTST);
    assign dest = INSN_I[exec_pkg::DEST_POS];

    alu_core u_alu (
        .acc_i(acc_q),
        .opnd_i(opnd),
        .bitsel_i(INSN_I[exec_pkg::BITSEL_HI:exec_pkg::BITSEL_LO]),
        .sum_o(sum),
        .carry_o(carry),
        .half_o(half),
        .and_o(andv),
        .clr_o(clrv),
        .tbit_o(tbit)
    );

    // Skip sequencer: a zero tested bit inserts one no-operation cycle.
    always_comb begin
        state_d = ST_RUN;
        unique case (state_q)
            ST_RUN: begin
                if (is_btst && !tbit) begin
                    state_d = ST_NOP;
                end
            end
            ST_NOP: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Accumulator takes byte results when the destination bit is zero.
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            acc_q <= exec_pkg::ACC_RESET;
        end else if (is_sum && !dest) begin
            acc_q <= sum;
        end else if (is_mask && !dest) begin
            acc_q <= andv;
        end
    end

    // Flags: the sum sets all three, the AND only null, bit operations none.
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            flags_q <= exec_pkg::FLAGS_RESET;
        end else if (is_sum) begin
            flags_q[exec_pkg::FLAG_CARRY] <= carry;
            flags_q[exec_pkg::FLAG_HALF] <= half;
            flags_q[exec_pkg::FLAG_NULL] <= (sum == 8'h00);
        end else if (is_mask) begin
            flags_q[exec_pkg::FLAG_NULL] <= (andv == 8'h00);
        end
    end

    // File write port, registered so every result lands one edge after decode.
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            we_q <= 1'b0;
            waddr_q <= 7'h00;
            wdata_q <= 8'h00;
        end else begin
            we_q <= ((is_sum || is_mask) && dest) || is_bclr;
            waddr_q <= INSN_I[6:0];
            wdata_q <= is_bclr ? clrv : (is_sum ? sum : andv);
        end
    end

    // Completion and discard strobes for the fetch unit.
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            discard_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            discard_q <= is_btst && !tbit;
            done_q <= is_sum || is_mask || is_bclr || (is_btst && tbit) || (state_q == ST_NOP);
        end
    end

    assign ACC_O = acc_q;
    assign CARRY_O = flags_q[exec_pkg::FLAG_CARRY];
    assign HALF_OVERFLOW_BIT_O = flags_q[exec_pkg::FLAG_HALF];
    assign NULL_O = flags_q[exec_pkg::FLAG_NULL];
    assign FILE_WE_O = we_q;
    assign FILE_WADDR_O = waddr_q;
    assign FILE_WDATA_O = wdata_q;
    assign DISCARD_O = discard_q;
    assign DONE_O = done_q;

    // Checks kept beside the logic they guard.
    sequence s_skip_taken;
        is_btst && !tbit;
    endsequence

    sequence s_nop_slot;
        (state_q == ST_NOP) ##1 (state_q == ST_RUN);
    endsequence

    property p_sum_acc;
        @(posedge MCLK_I) disable iff (RESET_I)
        (is_sum && !dest) |=> (ACC_O == $past(sum));
    endproperty
    a_sum_acc: assert property (p_sum_acc) else $error("sum not written to accumulator");

    property p_sum_flags;
        @(posedge MCLK_I) disable iff (RESET_I)
        is_sum |=> (CARRY_O == $past(carry)) && (HALF_OVERFLOW_BIT_O == $past(half));
    endproperty
    a_sum_flags: assert property (p_sum_flags) else $error("sum flags wrong");

    property p_dest_file;
        @(posedge MCLK_I) disable iff (RESET_I)
        ((is_sum || is_mask) && dest) |=> FILE_WE_O && $stable(ACC_O);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("destination one did not write file");

    property p_mask_flags;
        @(posedge MCLK_I) disable iff (RESET_I)
        is_mask |=> $stable(CARRY_O) && $stable(HALF_OVERFLOW_BIT_O) && (NULL_O == ($past(andv) == 8'h00));
    endproperty
    a_mask_flags: assert property (p_mask_flags) else $error("mask changed wrong flags");

    property p_bclr;
        @(posedge MCLK_I) disable iff (RESET_I)
        is_bclr |=> FILE_WE_O && (FILE_WDATA_O == $past(clrv)) && $stable(flags_q);
    endproperty
    a_bclr: assert property (p_bclr) else $error("bit clear wrong");

    property p_skip;
        @(posedge MCLK_I) disable iff (RESET_I)
        s_skip_taken |=> (DISCARD_O and s_nop_slot);
    endproperty
    a_skip: assert property (p_skip) else $error("skip did not insert one nop");

    property p_nop_no_effect;
        @(posedge MCLK_I) disable iff (RESET_I)
        (state_q == ST_NOP) |=> !FILE_WE_O && $stable(ACC_O) && $stable(flags_q) && DONE_O;
    endproperty
    a_nop_no_effect: assert property (p_nop_no_effect) else $error("squashed word took effect");

    property p_test_one;
        @(posedge MCLK_I) disable iff (RESET_I)
        (is_btst && tbit) |=> DONE_O && !DISCARD_O && (state_q == ST_RUN) && !FILE_WE_O;
    endproperty
    a_test_one: assert property (p_test_one) else $error("bit test one not single cycle");

    property p_port_read;
        @(posedge MCLK_I) disable iff (RESET_I)
        (is_bclr && IS_PORT_I) |=> (FILE_WDATA_O == ($past(PIN_RDATA_I) & ~(8'h01 << $past(INSN_I[9:7]))));
    endproperty
    a_port_read: assert property (p_port_read) else $error("port rewrite did not use pins");

    property p_null;
        @(posedge MCLK_I) disable iff (RESET_I)
        is_sum |=> (NULL_O == ($past(sum) == 8'h00)) && DONE_O;
    endproperty
    a_null: assert property (p_null) else $error("null flag wrong");
endmodule : file_alu_bit_ops_exec
